//--- bench/spip_peer.sv
// far-side serial device model, master or slave toward the block
`timescale 1ns/1ps
module spip_peer (
  input  wire logic sck_in,
  input  wire logic mosi_in,
  input  wire logic miso_in,
  output logic      sck_out,
  output logic      sck_oe_out,
  output logic      mosi_out,
  output logic      mosi_oe_out,
  output logic      ss_n_out,
  output logic      miso_out,
  output logic      miso_oe_out
);
  logic       slv_en = 1'b0;
  logic [7:0] sr     = 8'h00;
  logic       rbit   = 1'b0;
  initial begin
    sck_out     = 1'b0;
    sck_oe_out  = 1'b0;
    mosi_out    = 1'b0;
    mosi_oe_out = 1'b0;
    ss_n_out    = 1'b1;
  end
  // ---------------------------------
  // slave side
  // ---------------------------------
  always @(posedge sck_in) if (slv_en) rbit <= mosi_in;
  always @(negedge sck_in) if (slv_en) sr <= {sr[6:0], rbit};
  assign miso_out    = sr[7];
  assign miso_oe_out = slv_en;
  // ---------------------------------
  // master side, sel low leaves select high
  // ---------------------------------
  task automatic xfer(input logic [7:0] d, input logic sel, output logic [7:0] q);
    sck_out     = 1'b0;
    sck_oe_out  = 1'b1;
    mosi_oe_out = 1'b1;
    #200 ss_n_out = ~sel;
    #200;
    for (int i = 7; i >= 0; i--) begin
      mosi_out = d[i];
      #100 sck_out = 1'b1;
      q[i] = miso_in;
      #100 sck_out = 1'b0;
    end
    #200 ss_n_out = 1'b1;
    #200 sck_oe_out = 1'b0;
    mosi_oe_out = 1'b0;
    #200;
  endtask
endmodule // spip_peer

//--- bench/spip_top_tb_top.sv
// self-checking bench for the serial pin interface
`timescale 1ns/1ps
module spip_top_tb_top;
  import spip_pkg::*;
  logic       clk_sys_in = 1'b0;
  logic       nrst_in    = 1'b0;
  spip_role_t role       = SPIP_ROLE_MASTER;
  logic       od         = 1'b0;
  logic [3:0] sel        = 4'hf;
  logic [3:0] dir        = 4'h0;
  logic [3:0] dout       = 4'h0;
  logic       tx_valid   = 1'b0;
  logic [7:0] tx_data    = 8'h00;
  wire  [3:0] din, d_o, d_oe, p_o, p_oe, pin;
  logic [7:0] rx_data;
  logic       tx_ready, rx_valid, busy;
  int         fail_count = 0;
  int         checked    = 0;
  int         rx_cnt     = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (rx_valid === 1'b1) rx_cnt++;
  // ---------------------------------
  // pins: driver wins, else pull-up
  // ---------------------------------
  assign p_oe[3] = 1'b1;
  for (genvar g = 0; g < 4; g++) begin : g_pin
    assign pin[g] = d_oe[g] ? d_o[g] : (p_oe[g] ? p_o[g] : 1'b1);
  end
  spip_top i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .role_in(role),
    .open_drain_select_in(od), .pin_spi_sel_in(sel), .gpio_dir_in(dir),
    .gpio_dout_in(dout), .gpio_din_out(din), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .busy_out(busy), .miso_in(pin[0]), .miso_out(d_o[0]),
    .miso_oe_out(d_oe[0]), .mosi_in(pin[1]), .mosi_out(d_o[1]), .mosi_oe_out(d_oe[1]),
    .sck_in(pin[2]), .sck_out(d_o[2]), .sck_oe_out(d_oe[2]), .ss_n_in(pin[3]),
    .ss_n_out(d_o[3]), .ss_n_oe_out(d_oe[3]));
  spip_peer peer (.sck_in(pin[2]), .mosi_in(pin[1]), .miso_in(pin[0]),
    .sck_out(p_o[2]), .sck_oe_out(p_oe[2]), .mosi_out(p_o[1]), .mosi_oe_out(p_oe[1]),
    .ss_n_out(p_o[3]), .miso_out(p_o[0]), .miso_oe_out(p_oe[0]));
  // ---------------------------------
  // checks and scenarios
  // ---------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_gpio(input logic [3:0] dv, input logic [3:0] ov, input logic [3:0] pv);
    @(posedge clk_sys_in) begin sel <= 4'h0; dir <= dv; dout <= ov; end
    repeat (5) @(posedge clk_sys_in);
    check(d_oe, dv);
    check(d_o, ov);
    check(din, pv);
  endtask
  task automatic t_master(input logic odv);
    logic [7:0] wd[2];
    int n;
    wd = '{8'ha5, 8'h0f};
    @(posedge clk_sys_in) begin role <= SPIP_ROLE_MASTER; sel <= 4'h7; od <= odv; dir <= 4'h0; end
    repeat (3) @(posedge clk_sys_in);
    peer.slv_en = 1'b1;
    peer.sr = 8'h3c;
    for (int w = 0; w < 2; w++) begin
      @(posedge clk_sys_in) begin tx_valid <= 1'b1; tx_data <= wd[w]; end
      n = 0;
      do @(negedge clk_sys_in); while (tx_ready !== 1'b1 && ++n < 10);
      check(8'(tx_ready), 8'h01);
      check(8'(busy), 8'h00);
      @(posedge clk_sys_in) tx_valid <= 1'b0;
      n = 0;
      do begin
        @(negedge clk_sys_in);
        if (odv) check(8'(d_o[2:0] & d_oe[2:0]), 8'h00);
        else check(8'(d_oe[2:0]), 8'h06);
      end while (rx_valid !== 1'b1 && ++n < 100);
      check(8'(rx_valid), 8'h01);
      check(8'(busy), 8'h01);
      check(rx_data, w == 0 ? 8'h3c : 8'ha5);
      repeat (6) @(negedge clk_sys_in);
      check(peer.sr, wd[w]);
      check(8'(busy), 8'h00);
    end
    peer.slv_en = 1'b0;
  endtask
  task automatic t_slave(input logic odv);
    logic [7:0] q;
    int n;
    @(posedge clk_sys_in) begin role <= SPIP_ROLE_SLAVE; sel <= 4'hf; od <= odv; end
    @(posedge clk_sys_in) tx_data <= 8'h96;
    repeat (4) @(posedge clk_sys_in);
    check(8'(d_oe[2:0]), 8'h00);
    n = rx_cnt;
    #7 peer.xfer(8'h5a, 1'b0, q);
    check(8'(rx_cnt - n), 8'h00);
    peer.xfer(8'h5a, 1'b1, q);
    check(q, 8'h96);
    check(rx_data, 8'h5a);
    check(8'(rx_cnt - n), 8'h01);
    check(8'(busy), 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_in);
    check(d_oe, 4'h0);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    t_gpio(4'h5, 4'ha, 4'ha);
    t_gpio(4'hf, 4'h5, 4'h5);
    t_master(1'b0);
    t_master(1'b1);
    t_slave(1'b0);
    t_slave(1'b1);
    summarize();
  end
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
endmodule // spip_top_tb_top

//--- hw/spip_shifter.sv
// shift register shared by master and slave transfers
`timescale 1ns/1ps
module spip_shifter #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         nrst_in,
  // control strobes
  input  wire logic         load_in,
  input  wire logic [W-1:0] load_data_in,
  input  wire logic         sample_in,
  input  wire logic         shift_in,
  input  wire logic         rx_bit_in,
  // results
  output logic              tx_bit_out,
  output logic              last_out,
  output logic              word_done_out,
  output logic [W-1:0]      rx_data_out
);
  logic [W-1:0]         tx_sh_r;
  logic [W-1:0]         rx_sh_r;
  logic [$clog2(W+1)-1:0] bit_cnt_r;
  logic [W-1:0]         rx_nxt;

  assign rx_nxt        = {rx_sh_r[W-2:0], rx_bit_in};
  assign tx_bit_out    = tx_sh_r[W-1];
  assign last_out      = (bit_cnt_r == ($clog2(W+1))'(W));

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      tx_sh_r <= '0;
    end else if (load_in) begin
      tx_sh_r <= load_data_in;
    end else if (shift_in) begin
      tx_sh_r <= {tx_sh_r[W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rx_sh_r       <= '0;
      bit_cnt_r     <= '0;
      word_done_out <= 1'b0;
      rx_data_out   <= '0;
    end else begin
      word_done_out <= 1'b0;
      if (load_in) begin
        bit_cnt_r <= '0;
      end else if (sample_in) begin
        rx_sh_r   <= rx_nxt;
        bit_cnt_r <= bit_cnt_r + 1'b1;
        if (bit_cnt_r == ($clog2(W+1))'(W-1)) begin
          word_done_out <= 1'b1;
          rx_data_out   <= rx_nxt;
        end
      end
    end
  end
endmodule // spip_shifter

//--- hw/spip_top.sv
// serial peripheral pin interface with per-pin general-purpose fallback
`timescale 1ns/1ps
`include "spip_consts.svh"

// What this block does
// [RULE1] master reads miso, slave drives it
// [RULE2] unselected slave releases miso driver
// [RULE3] open_drain_select makes spi drivers open-drain
// [RULE4] master drives mosi, slave samples it
// [RULE5] mosi bit set half period before capture
// [RULE6] master makes sck, slave takes it in
// [RULE7] slave ignores sck while select high
// [RULE8] shift on one edge, sample opposite
// [RULE9] master holds select low whole transfer; code drives ss_n_out only as gpio, ss_n_oe_out is 0 when pin 3 is select
// [RULE10] select input held high when master
// [RULE11] non-spi pins are individual gpio
// [RULE12] per-pin function select, gpio after reset
module spip_top #(
  parameter int DATA_W   = `SPIP_WORD_BITS,
  parameter int HALF_CYC = `SPIP_SCK_HALF_CYC
) (
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              nrst_in,
  // configuration
  input  wire spip_pkg::spip_role_t role_in,
  input  wire logic              open_drain_select_in,
  input  wire logic [3:0]        pin_spi_sel_in,
  // general-purpose port f
  input  wire logic [3:0]        gpio_dir_in,
  input  wire logic [3:0]        gpio_dout_in,
  output logic      [3:0]        gpio_din_out,
  // transfer data
  input  wire logic              tx_valid_in,
  input  wire logic [DATA_W-1:0] tx_data_in,
  output logic                   tx_ready_out,
  output logic                   rx_valid_out,
  output logic      [DATA_W-1:0] rx_data_out,
  output logic                   busy_out,
  // port_f_line_0 / miso
  input  wire logic              miso_in,
  output logic                   miso_out,
  output logic                   miso_oe_out,
  // port_f_line_1 / mosi
  input  wire logic              mosi_in,
  output logic                   mosi_out,
  output logic                   mosi_oe_out,
  // port_f_line_2 / sck
  input  wire logic              sck_in,
  output logic                   sck_out,
  output logic                   sck_oe_out,
  // port_f_line_3 / slave select
  input  wire logic              ss_n_in,
  output logic                   ss_n_out,
  output logic                   ss_n_oe_out
);
  import spip_pkg::*;

  // ----------------------------------------------------------------
  // configuration capture
  // ----------------------------------------------------------------
  logic [3:0]        pin_sel_r;
  logic              od_r;
  spip_role_t        role_r;
  logic              is_master;

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      pin_sel_r <= `SPIP_PIN_SEL_RST; // [RULE12]
      od_r      <= 1'b0;
      role_r    <= SPIP_ROLE_SLAVE;
    end else begin
      pin_sel_r <= pin_spi_sel_in; // [RULE12]
      od_r      <= open_drain_select_in;
      role_r    <= role_in;
    end
  end

  assign is_master = (role_r == SPIP_ROLE_MASTER);

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic [3:0] pin_s3_r;

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      pin_s1_r <= 4'hF;
      pin_s2_r <= 4'hF;
      pin_s3_r <= 4'hF;
    end else begin
      pin_s1_r <= {ss_n_in, sck_in, mosi_in, miso_in};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      gpio_din_out <= 4'h0;
    end else begin
      gpio_din_out <= pin_s2_r; // [RULE11]
    end
  end

  // ----------------------------------------------------------------
  // master clock generator
  // ----------------------------------------------------------------
  spip_state_t        state_r;
  logic [15:0]        half_cnt_r;
  logic               sck_r;
  logic               half_end;
  logic               m_start;
  logic               m_sample;
  logic               m_shift;
  logic               last;
  logic               m_enable;

  assign m_enable = is_master && pin_sel_r[`SPIP_PIN_MOSI] && pin_sel_r[`SPIP_PIN_SCK];
  assign half_end = (half_cnt_r == 16'(HALF_CYC - 1));
  assign m_start  = (state_r == SPIP_ST_IDLE) && m_enable && tx_valid_in;
  assign m_sample = (state_r == SPIP_ST_LOW) && half_end;
  assign m_shift  = (state_r == SPIP_ST_HIGH) && half_end && !last;

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_r    <= SPIP_ST_IDLE;
      half_cnt_r <= 16'h0000;
      sck_r      <= 1'b0;
    end else begin
      half_cnt_r <= half_end ? 16'h0000 : half_cnt_r + 16'h0001;
      case (state_r)
        SPIP_ST_IDLE: begin
          half_cnt_r <= 16'h0000;
          sck_r      <= 1'b0;
          if (m_start) begin
            state_r <= SPIP_ST_LOW; // bit out a half period ahead [RULE5]
          end
        end
        SPIP_ST_LOW: begin
          if (half_end) begin
            sck_r   <= 1'b1; // capture edge [RULE6]
            state_r <= SPIP_ST_HIGH;
          end
        end
        SPIP_ST_HIGH: begin
          if (half_end) begin
            sck_r   <= 1'b0; // change edge [RULE8]
            state_r <= last ? SPIP_ST_IDLE : SPIP_ST_LOW;
          end
        end
        default: begin
          state_r <= SPIP_ST_IDLE;
          sck_r   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // slave edge detection
  // ----------------------------------------------------------------
  logic s_active;
  logic s_rise;
  logic s_fall;
  logic s_ss_fell;
  logic s_sample;
  logic s_shift;
  logic s_load;

  assign s_active  = !is_master && pin_sel_r[`SPIP_PIN_SS] && !pin_s2_r[3]; // [RULE7] [RULE9]
  assign s_rise    = pin_s2_r[2] && !pin_s3_r[2];
  assign s_fall    = !pin_s2_r[2] && pin_s3_r[2];
  assign s_ss_fell = !is_master && pin_sel_r[`SPIP_PIN_SS] && !pin_s2_r[3] && pin_s3_r[3];
  assign s_sample  = s_active && s_rise; // [RULE7] [RULE8]
  assign s_shift   = s_active && s_fall && !last; // [RULE8]
  assign s_load    = s_ss_fell || (s_active && s_fall && last);

  // ----------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------
  logic              load;
  logic              sample;
  logic              shift;
  logic              rx_bit;
  logic              tx_bit;
  logic              word_done;

  assign load   = m_start || s_load;
  assign sample = is_master ? m_sample : s_sample;
  assign shift  = is_master ? m_shift : s_shift;
  assign rx_bit = is_master ? pin_s2_r[`SPIP_PIN_MISO] : pin_s2_r[`SPIP_PIN_MOSI]; // [RULE1] [RULE4]

  spip_shifter #(
    .W (DATA_W)
  ) u_shifter (
    .clk_sys_in    (clk_sys_in),
    .nrst_in       (nrst_in),
    .load_in       (load),
    .load_data_in  (tx_data_in),
    .sample_in     (sample),
    .shift_in      (shift),
    .rx_bit_in     (rx_bit),
    .tx_bit_out    (tx_bit),
    .last_out      (last),
    .word_done_out (word_done),
    .rx_data_out   (rx_data_out)
  );

  assign tx_ready_out = load;
  assign rx_valid_out = word_done;
  assign busy_out     = (state_r != SPIP_ST_IDLE) || s_active;

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic miso_drv;
  logic mosi_drv;
  logic sck_drv;

  assign miso_drv = !is_master && !pin_s2_r[3]; // [RULE1] [RULE2]
  assign mosi_drv = is_master; // [RULE4] [RULE10]
  assign sck_drv  = is_master; // [RULE6]

  always_comb begin
    // port f gpio defaults [RULE11]
    miso_out    = gpio_dout_in[0];
    miso_oe_out = gpio_dir_in[0];
    mosi_out    = gpio_dout_in[1];
    mosi_oe_out = gpio_dir_in[1];
    sck_out     = gpio_dout_in[2];
    sck_oe_out  = gpio_dir_in[2];
    ss_n_out    = gpio_dout_in[3];
    ss_n_oe_out = gpio_dir_in[3];
    if (pin_sel_r[`SPIP_PIN_MISO]) begin
      miso_out    = od_r ? 1'b0 : tx_bit; // [RULE3]
      miso_oe_out = miso_drv && (!od_r || !tx_bit); // [RULE2] [RULE3]
    end
    if (pin_sel_r[`SPIP_PIN_MOSI]) begin
      mosi_out    = od_r ? 1'b0 : tx_bit; // [RULE3]
      mosi_oe_out = mosi_drv && (!od_r || !tx_bit); // [RULE3] [RULE4]
    end
    if (pin_sel_r[`SPIP_PIN_SCK]) begin
      sck_out     = od_r ? 1'b0 : sck_r; // [RULE3]
      sck_oe_out  = sck_drv && (!od_r || !sck_r); // [RULE3] [RULE6]
    end
    if (pin_sel_r[`SPIP_PIN_SS]) begin
      ss_n_out    = 1'b0;
      ss_n_oe_out = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_miso_master_in: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [RULE1]
    (is_master && pin_sel_r[0]) |-> !miso_oe_out)
    else $error("master drives miso");

  a_miso_unsel_release: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [RULE2]
    (!is_master && pin_sel_r[0] && pin_s2_r[3]) |-> !miso_oe_out)
    else $error("unselected slave drives miso");

  a_open_drain_low: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [RULE3]
    (od_r && pin_sel_r[2] && sck_oe_out) |-> (!sck_out && !sck_r))
    else $error("open-drain sck driven high");

  a_mosi_direction: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [RULE4]
    (pin_sel_r[1] && !od_r) |-> (mosi_oe_out == is_master))
    else $error("mosi direction wrong");

  a_mosi_setup_half: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [RULE5]
    (is_master && $rose(sck_r) && HALF_CYC > 1) |-> (tx_bit == $past(tx_bit, 2)))
    else $error("mosi changed within half period of capture");

  a_sck_period: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [RULE6]
    $rose(sck_r) |-> sck_r [*4] ##1 !sck_r)
    else $error("sck high time wrong");

  a_slave_ignore: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [RULE7]
    (!is_master && pin_s2_r[3]) |-> (!sample && !shift))
    else $error("slave reacted while deselected");

  a_edge_split: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [RULE8]
    (m_sample |-> ##1 (sck_r && !m_shift)) and (m_shift |=> !sck_r))
    else $error("shift and sample edges not opposite");

  a_gpio_fallback: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [RULE11]
    !pin_sel_r[3] |-> (ss_n_oe_out == gpio_dir_in[3] && ss_n_out == gpio_dout_in[3]))
    else $error("gpio fallback wrong");

  a_reset_gpio: assert property (@(posedge clk_sys_in) // [RULE12]
    $rose(nrst_in) |-> (pin_sel_r == 4'h0))
    else $error("pins not gpio after reset");
endmodule // spip_top

//--- inc/spip_consts.svh
// timing and reset constants for the serial pin interface
`ifndef SPIP_CONSTS_SVH
`define SPIP_CONSTS_SVH
`define SPIP_CLK_PERIOD_NS  25
`define SPIP_SCK_HALF_NS    100
`define SPIP_SCK_HALF_CYC   (`SPIP_SCK_HALF_NS / `SPIP_CLK_PERIOD_NS)
`define SPIP_WORD_BITS      8
`define SPIP_PIN_MISO       0
`define SPIP_PIN_MOSI       1
`define SPIP_PIN_SCK        2
`define SPIP_PIN_SS         3
`define SPIP_PIN_SEL_RST    4'h0
`endif

//--- inc/spip_pkg.sv
// types for the serial pin interface
package spip_pkg;
  typedef enum logic [1:0] {
    SPIP_ST_IDLE = 2'b00,
    SPIP_ST_LOW  = 2'b01,
    SPIP_ST_HIGH = 2'b10
  } spip_state_t;
  typedef enum logic {
    SPIP_ROLE_SLAVE  = 1'b0,
    SPIP_ROLE_MASTER = 1'b1
  } spip_role_t;
endpackage
